// [shared/bwm_params.svh]
/*
 constants of the breaker wear monitor: widths, register offsets, reset values.
 assumes inclusion by bare name from the package and the design files.
*/
`ifndef BWM_PARAMS_SVH
`define BWM_PARAMS_SVH

`define BWM_CNT_W 18
`define BWM_CUR_W 16
`define BWM_TS_W 48
`define BWM_LOG_N 12
`define BWM_EV_N 5

`define BWM_A1_SET_DEF 18'h0_03e8
`define BWM_A2_SET_DEF 18'h0_0064
`define BWM_START_DEF 18'h0_c350
`define BWM_MODE_DEF 2'h3

`define BWM_CTRL_A1EN 0
`define BWM_CTRL_A2EN 1
`define BWM_CTRL_MODE 2
`define BWM_CTRL_CLR 4
`define BWM_CTRL_LOAD 5

`define BWM_A_CTRL 8'h00
`define BWM_A_A1SET 8'h04
`define BWM_A_A2SET 8'h08
`define BWM_A_START 8'h0c
`define BWM_A_STAT 8'h10
`define BWM_A_OPS 8'h14
`define BWM_A_A1CNT 8'h18
`define BWM_A_A2CNT 8'h1c
`define BWM_A_LEFT0 8'h20
`define BWM_A_IRQST 8'h2c
`define BWM_A_IRQMSK 8'h30
`define BWM_A_LOGSEL 8'h34
`define BWM_A_LOGCNT 8'h38
`define BWM_A_LOG0 8'h40

`endif

// [shared/bwm_pkg.sv]
/*
 types of the breaker wear monitor.
 assumes bwm_params.svh is on the include path.
*/
`include "bwm_params.svh"

package bwm_pkg;
	typedef enum logic [1:0] {bwm_normal, bwm_alarm1_on, bwm_alarm2_on} bwm_cond_t;
	typedef enum logic [2:0] {bwm_ev_trig, bwm_ev_a1_on, bwm_ev_a1_off, bwm_ev_a2_on,
		bwm_ev_a2_off} bwm_ev_t;
	typedef logic [`BWM_CNT_W-1:0] bwm_cnt_t;
endpackage

// [design/bwm_phase_cnt.sv]
/*
 remaining-operations counter of one phase, saturating at zero.
 assumes trig and load are one-cycle pulses on clk.
*/
`timescale 1ns/1ns
`include "bwm_params.svh"

module bwm_phase_cnt (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// control
	input wire logic load,
	input wire bwm_pkg::bwm_cnt_t start,
	input wire logic trig,
	input wire bwm_pkg::bwm_cnt_t cost,
	// state
	output bwm_pkg::bwm_cnt_t left
);
	bwm_pkg::bwm_cnt_t left_r;
	bwm_pkg::bwm_cnt_t left_nxt;

	always_comb
	begin
		left_nxt = left_r;
		if (load)
			left_nxt = start;
		else if (trig)
			left_nxt = (left_r > cost) ? left_r - cost : '0;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			left_r <= `BWM_START_DEF;
		else
			left_r <= left_nxt;
	end

	assign left = left_r;

	a_left_deduct: assert property (@(posedge clk) disable iff (!nrst)
		(trig && !load) |=> left_r == (($past(left_r) > $past(cost)) ?
		$past(left_r) - $past(cost) : '0))
		else $error("remaining count not deducted with saturation");
endmodule

// [design/bwm_monitor.sv]
/*
 breaker wear monitor: per-phase remaining operations, two alarm stages,
 counters, time-stamped events, twelve-entry log and a register port.
 assumes trigger, currents, costs and time come from logic on clk.
*/
// The implementer's own choices: the address map and strobed register access.
//
// Function
// - alarm 1 has an enable, reset disabled; disabled means alarm 1 stays low
// - alarm 1 is high while any remaining count is below threshold 1 (1000)
// - alarm 2 has its own enable, reset disabled; disabled keeps alarm 2 low
// - alarm 2 is high while any remaining count is below threshold 2 (100)
// - each threshold is shared by three phases; any phase below picks up
// - a readable wear condition: normal, alarm 1 on, alarm 2 on
// - a readable counter counts every breaker open trigger
// - three remaining counts, one per phase, feed the comparisons
// - alarm activation counters and the open counter clear on request
// - five events; a mode selects storing ON, OFF or both
// - every event carries a time stamp; alarms are also plain outputs
// - the last twelve ON records are kept in a rolling log
// - a record holds time, event, currents, deductions and counts left
// - each trigger deducts the per-phase cost from its count
`timescale 1ns/1ns
`include "bwm_params.svh"

module bwm_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// open trigger and measurements
	input wire logic trig,
	input wire logic [3*`BWM_CUR_W-1:0] cur,
	input wire logic [3*`BWM_CNT_W-1:0] cost,
	input wire logic [`BWM_TS_W-1:0] time_ms,
	// alarms, events, interrupt
	output logic alarm1,
	output logic alarm2,
	output logic [`BWM_EV_N-1:0] ev_pulse,
	output logic [`BWM_TS_W-1:0] ev_stamp,
	output logic irq
);

	function automatic logic any_below(input logic [3*`BWM_CNT_W-1:0] l,
		input bwm_pkg::bwm_cnt_t thr);
		logic b;
		b = 1'b0;
		for (int i = 0; i < 3; i++)
			b = b | (l[i*`BWM_CNT_W +: `BWM_CNT_W] < thr);
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// settings and status registers

	logic a1en_r, a1en_nxt, a2en_r, a2en_nxt;
	logic [1:0] mode_r, mode_nxt;
	bwm_pkg::bwm_cnt_t a1set_r, a1set_nxt, a2set_r, a2set_nxt, start_r, start_nxt;
	logic [`BWM_EV_N-1:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
	logic [3:0] lsel_r, lsel_nxt;
	logic clr, load;
	logic [`BWM_EV_N-1:0] ev_nxt;
	logic wr_ctrl;

	assign wr_ctrl = wr && addr == `BWM_A_CTRL;
	assign clr = wr_ctrl && wdata[`BWM_CTRL_CLR];
	assign load = wr_ctrl && wdata[`BWM_CTRL_LOAD];

	always_comb
	begin
		a1en_nxt = a1en_r;
		a2en_nxt = a2en_r;
		mode_nxt = mode_r;
		a1set_nxt = a1set_r;
		a2set_nxt = a2set_r;
		start_nxt = start_r;
		imsk_nxt = imsk_r;
		lsel_nxt = lsel_r;
		ist_nxt = ist_r;
		if (wr)
		begin
			unique case (addr)
				`BWM_A_CTRL:
				begin
					a1en_nxt = wdata[`BWM_CTRL_A1EN];
					a2en_nxt = wdata[`BWM_CTRL_A2EN];
					mode_nxt = wdata[`BWM_CTRL_MODE +: 2];
				end
				`BWM_A_A1SET: a1set_nxt = wdata[`BWM_CNT_W-1:0];
				`BWM_A_A2SET: a2set_nxt = wdata[`BWM_CNT_W-1:0];
				`BWM_A_START: start_nxt = wdata[`BWM_CNT_W-1:0];
				`BWM_A_IRQST: ist_nxt = ist_r & ~wdata[`BWM_EV_N-1:0];
				`BWM_A_IRQMSK: imsk_nxt = wdata[`BWM_EV_N-1:0];
				`BWM_A_LOGSEL: lsel_nxt = wdata[3:0];
				default: ;
			endcase
		end
		// a new event beats a clear in the same cycle
		ist_nxt = ist_nxt | ev_nxt;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			a1en_r <= 1'b0;
			a2en_r <= 1'b0;
			mode_r <= `BWM_MODE_DEF;
			a1set_r <= `BWM_A1_SET_DEF;
			a2set_r <= `BWM_A2_SET_DEF;
			start_r <= `BWM_START_DEF;
			ist_r <= '0;
			imsk_r <= '0;
			lsel_r <= '0;
		end
		else
		begin
			a1en_r <= a1en_nxt;
			a2en_r <= a2en_nxt;
			mode_r <= mode_nxt;
			a1set_r <= a1set_nxt;
			a2set_r <= a2set_nxt;
			start_r <= start_nxt;
			ist_r <= ist_nxt;
			imsk_r <= imsk_nxt;
			lsel_r <= lsel_nxt;
		end
	end

	assign irq = |(ist_r & imsk_r);

	////////////////////////////////////////////////////////////////////////////
	// per-phase remaining counts

	logic [3*`BWM_CNT_W-1:0] left;

	for (genvar p = 0; p < 3; p++)
	begin : g_phase
		bwm_phase_cnt u_cnt (
			.clk(clk),
			.nrst(nrst),
			.load(load),
			.start(start_r),
			.trig(trig),
			.cost(cost[p*`BWM_CNT_W +: `BWM_CNT_W]),
			.left(left[p*`BWM_CNT_W +: `BWM_CNT_W])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// alarms, counters, events

	logic a1_r, a1_nxt, a2_r, a2_nxt;
	bwm_pkg::bwm_cnt_t ops_r, ops_nxt, a1c_r, a1c_nxt, a2c_r, a2c_nxt;
	logic [`BWM_EV_N-1:0] evall_r, evp_r, evp_nxt;
	logic [`BWM_TS_W-1:0] ts_r, ts_nxt;
	logic [3*`BWM_CUR_W-1:0] cur_r, cur_nxt;
	logic [3*`BWM_CNT_W-1:0] ded_r, ded_nxt;
	bwm_pkg::bwm_cond_t cond;

	always_comb
	begin
		a1_nxt = a1en_r && any_below(left, a1set_r);
		a2_nxt = a2en_r && any_below(left, a2set_r);
		ev_nxt[bwm_pkg::bwm_ev_trig] = trig;
		ev_nxt[bwm_pkg::bwm_ev_a1_on] = a1_nxt && !a1_r;
		ev_nxt[bwm_pkg::bwm_ev_a1_off] = !a1_nxt && a1_r;
		ev_nxt[bwm_pkg::bwm_ev_a2_on] = a2_nxt && !a2_r;
		ev_nxt[bwm_pkg::bwm_ev_a2_off] = !a2_nxt && a2_r;
		// store mode: bit 0 passes ON events, bit 1 passes OFF events
		evp_nxt = ev_nxt & {mode_r[1], mode_r[0], mode_r[1], mode_r[0], mode_r[0]};
		ts_nxt = (|ev_nxt) ? time_ms : ts_r;
		// clear first, then count, so a coincident event survives the clear
		ops_nxt = (clr ? '0 : ops_r) + bwm_pkg::bwm_cnt_t'(trig);
		a1c_nxt = (clr ? '0 : a1c_r) + bwm_pkg::bwm_cnt_t'(ev_nxt[1]);
		a2c_nxt = (clr ? '0 : a2c_r) + bwm_pkg::bwm_cnt_t'(ev_nxt[3]);
		cur_nxt = trig ? cur : cur_r;
		ded_nxt = trig ? cost : ded_r;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			a1_r <= 1'b0;
			a2_r <= 1'b0;
			evall_r <= '0;
			evp_r <= '0;
			ts_r <= '0;
			ops_r <= '0;
			a1c_r <= '0;
			a2c_r <= '0;
			cur_r <= '0;
			ded_r <= '0;
		end
		else
		begin
			a1_r <= a1_nxt;
			a2_r <= a2_nxt;
			evall_r <= ev_nxt;
			evp_r <= evp_nxt;
			ts_r <= ts_nxt;
			ops_r <= ops_nxt;
			a1c_r <= a1c_nxt;
			a2c_r <= a2c_nxt;
			cur_r <= cur_nxt;
			ded_r <= ded_nxt;
		end
	end

	assign alarm1 = a1_r;
	assign alarm2 = a2_r;
	assign ev_pulse = evp_r;
	assign ev_stamp = ts_r;
	assign cond = a2_r ? bwm_pkg::bwm_alarm2_on :
		(a1_r ? bwm_pkg::bwm_alarm1_on : bwm_pkg::bwm_normal);

	////////////////////////////////////////////////////////////////////////////
	// rolling log; one record per cycle, alarm 2 ON before alarm 1 ON before trigger

	logic [`BWM_TS_W-1:0] lts_r [`BWM_LOG_N];
	logic [2:0] lev_r [`BWM_LOG_N];
	logic [3*`BWM_CUR_W-1:0] lcur_r [`BWM_LOG_N];
	logic [3*`BWM_CNT_W-1:0] lded_r [`BWM_LOG_N], lleft_r [`BWM_LOG_N];
	logic [3:0] wp_r, wp_nxt, lcnt_r, lcnt_nxt;
	logic lwr;
	logic [2:0] lev;

	always_comb
	begin
		lwr = evall_r[0] | evall_r[1] | evall_r[3];
		lev = evall_r[3] ? 3'(bwm_pkg::bwm_ev_a2_on) :
			(evall_r[1] ? 3'(bwm_pkg::bwm_ev_a1_on) : 3'(bwm_pkg::bwm_ev_trig));
		wp_nxt = wp_r;
		lcnt_nxt = lcnt_r;
		if (lwr)
		begin
			wp_nxt = (wp_r == 4'(`BWM_LOG_N - 1)) ? '0 : wp_r + 4'h1;
			lcnt_nxt = (lcnt_r == 4'(`BWM_LOG_N)) ? lcnt_r : lcnt_r + 4'h1;
		end
	end

	// records are plain storage, so they need no reset
	always_ff @(posedge clk)
	begin
		if (lwr)
		begin
			lts_r[wp_r] <= ts_r;
			lev_r[wp_r] <= lev;
			lcur_r[wp_r] <= cur_r;
			lded_r[wp_r] <= ded_r;
			lleft_r[wp_r] <= left;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wp_r <= '0;
			lcnt_r <= '0;
		end
		else
		begin
			wp_r <= wp_nxt;
			lcnt_r <= lcnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port: data in the cycle after the strobe, zero otherwise

	logic [31:0] rdata_r, rdata_nxt;
	logic [3:0] ridx;
	logic [3:0] rfld;

	always_comb
	begin
		ridx = (wp_r > lsel_r) ? wp_r - lsel_r - 4'h1 : wp_r + 4'(`BWM_LOG_N - 1) - lsel_r;
		rfld = 4'(addr[5:2]);
		rdata_nxt = '0;
		if (rd)
		begin
			unique case (addr)
				`BWM_A_CTRL: rdata_nxt = 32'({mode_r, a2en_r, a1en_r});
				`BWM_A_A1SET: rdata_nxt = 32'(a1set_r);
				`BWM_A_A2SET: rdata_nxt = 32'(a2set_r);
				`BWM_A_START: rdata_nxt = 32'(start_r);
				`BWM_A_STAT: rdata_nxt = 32'({a2_r, a1_r, cond});
				`BWM_A_OPS: rdata_nxt = 32'(ops_r);
				`BWM_A_A1CNT: rdata_nxt = 32'(a1c_r);
				`BWM_A_A2CNT: rdata_nxt = 32'(a2c_r);
				`BWM_A_IRQST: rdata_nxt = 32'(ist_r);
				`BWM_A_IRQMSK: rdata_nxt = 32'(imsk_r);
				`BWM_A_LOGSEL: rdata_nxt = 32'(lsel_r);
				`BWM_A_LOGCNT: rdata_nxt = 32'(lcnt_r);
				default:
				begin
					if (addr >= `BWM_A_LEFT0 && addr < `BWM_A_IRQST && addr[1:0] == 2'h0)
						rdata_nxt = 32'(left[(addr[3:2] ^ 2'h0) * `BWM_CNT_W +: `BWM_CNT_W]);
					else if (addr >= `BWM_A_LOG0 && addr[7:6] == 2'h1 && addr[1:0] == 2'h0
						&& rfld < 4'(`BWM_LOG_N) && lsel_r < lcnt_r)
					begin
						unique case (rfld)
							4'h0: rdata_nxt = lts_r[ridx][31:0];
							4'h1: rdata_nxt = 32'(lts_r[ridx][`BWM_TS_W-1:32]);
							4'h2: rdata_nxt = 32'(lev_r[ridx]);
							4'h3, 4'h4, 4'h5:
								rdata_nxt = 32'(lcur_r[ridx][(rfld-4'h3)*`BWM_CUR_W +: `BWM_CUR_W]);
							4'h6, 4'h7, 4'h8:
								rdata_nxt = 32'(lded_r[ridx][(rfld-4'h6)*`BWM_CNT_W +: `BWM_CNT_W]);
							default:
								rdata_nxt = 32'(lleft_r[ridx][(rfld-4'h9)*`BWM_CNT_W +: `BWM_CNT_W]);
						endcase
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdata_r <= '0;
		else
			rdata_r <= rdata_nxt;
	end

	assign rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////
	// checks

	a_a1_disabled: assert property (@(posedge clk) disable iff (!nrst)
		!a1en_r |=> !alarm1) else $error("alarm 1 high while disabled");
	a_a1_pickup: assert property (@(posedge clk) disable iff (!nrst)
		(a1en_r && left[17:0] < a1set_r) |=> alarm1) else $error("alarm 1 missed");
	a_a2_disabled: assert property (@(posedge clk) disable iff (!nrst)
		!a2en_r |=> !alarm2) else $error("alarm 2 high while disabled");
	a_a2_pickup: assert property (@(posedge clk) disable iff (!nrst)
		(a2en_r && left[53:36] < a2set_r) |=> alarm2) else $error("alarm 2 missed");
	a_any_phase: assert property (@(posedge clk) disable iff (!nrst)
		alarm1 |-> $past(any_below(left, a1set_r))) else $error("alarm 1 without cause");
	a_cond_code: assert property (@(posedge clk) disable iff (!nrst)
		(alarm2 |-> cond == bwm_pkg::bwm_alarm2_on) and (!alarm1 && !alarm2 |->
		cond == bwm_pkg::bwm_normal)) else $error("wear condition wrong");
	a_ops_count: assert property (@(posedge clk) disable iff (!nrst)
		(trig && !clr) |=> ops_r == $past(ops_r) + 18'h0_0001) else $error("open not counted");
	a_a1_count: assert property (@(posedge clk) disable iff (!nrst)
		($rose(alarm1) && !$past(clr)) |-> a1c_r == $past(a1c_r) + 18'h0_0001)
		else $error("alarm 1 activation not counted");
	a_trig_event: assert property (@(posedge clk) disable iff (!nrst)
		(trig && mode_r[0]) |=> ev_pulse[0] && ev_stamp == $past(time_ms))
		else $error("trigger event or stamp missing");
	a_log_adv: assert property (@(posedge clk) disable iff (!nrst)
		trig |=> ##1 (wp_r != $past(wp_r, 2) && wp_r < 4'(`BWM_LOG_N)))
		else $error("log not advanced");
endmodule

// [verification/bwm_trig_src.sv]
/*
 open-command trigger source: one trigger pulse per open, currents, costs, running time.
 assumes the bench calls open_op from its own sequence, on clk.
*/
`timescale 1ns/1ns
`include "bwm_params.svh"

module bwm_trig_src (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// measurements toward the monitor
	output logic trig,
	output logic [3*`BWM_CUR_W-1:0] cur,
	output logic [3*`BWM_CNT_W-1:0] cost,
	output logic [`BWM_TS_W-1:0] time_ms
);
	logic [`BWM_TS_W-1:0] t_last;
	initial
	begin
		trig = 1'b0;
		cur = '0;
		cost = '0;
		t_last = '0;
	end
	always @(posedge clk or negedge nrst)
		if (!nrst)
			time_ms <= 48'h0000_0000_0000;
		else
			time_ms <= time_ms + 48'h0000_0000_0001;
	////////////////////////////////////////////////////////////////////////////////
	// one pulse per open; values are inverted afterwards so stale sampling shows
	task automatic open_op(input logic [17:0] c1, input logic [17:0] c2, input logic [17:0] c3);
		@(posedge clk);
		trig <= 1'b1;
		cost <= {c3, c2, c1};
		cur <= {c3[15:0] ^ 16'h5a5a, c2[15:0] ^ 16'h5a5a, c1[15:0] ^ 16'h5a5a};
		#1 t_last = time_ms;
		@(posedge clk);
		trig <= 1'b0;
		cost <= ~cost;
		cur <= ~cur;
		repeat (4) @(posedge clk);
	endtask
endmodule

// [verification/bwm_monitor_bench.sv]
/*
 self-checking bench of the wear monitor, register reads and writes plus open triggers.
 assumes bwm_trig_src stands in for the open-command trigger and measurements.
*/
`timescale 1ns/1ns
`include "bwm_params.svh"

module bwm_monitor_bench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic trig;
	logic [3*`BWM_CUR_W-1:0] cur;
	logic [3*`BWM_CNT_W-1:0] cost;
	logic [`BWM_TS_W-1:0] time_ms;
	logic alarm1;
	logic alarm2;
	logic [`BWM_EV_N-1:0] ev_pulse;
	logic [`BWM_TS_W-1:0] ev_stamp;
	logic irq;
	int errors = 0;
	int tests_run = 0;
	int ev_n [5] = '{0, 0, 0, 0, 0};
	logic [31:0] v;

	always #5 clk = ~clk;

	bwm_monitor bwm_monitor_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .trig(trig), .cur(cur), .cost(cost), .time_ms(time_ms),
		.alarm1(alarm1), .alarm2(alarm2), .ev_pulse(ev_pulse), .ev_stamp(ev_stamp), .irq(irq));
	bwm_trig_src bwm_trig_src_i (.clk(clk), .nrst(nrst), .trig(trig), .cur(cur), .cost(cost),
		.time_ms(time_ms));

	always @(posedge clk)
		for (int i = 0; i < 5; i++)
			if (ev_pulse[i] === 1'b1)
				ev_n[i]++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, so they are taken there
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		rd_reg(a, v);
		chk({16'h0000, v}, {16'h0000, exp});
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#200000;
		errors++;
		tally_and_finish();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rd_chk(`BWM_A_A1SET, 32'h0000_03e8);
		rd_chk(`BWM_A_A2SET, 32'h0000_0064);
		rd_chk(`BWM_A_CTRL, 32'h0000_000c);
		rd_chk(`BWM_A_LEFT0 + 8'h04, 32'h0000_c350);
		rd_chk(8'h3c, 32'h0000_0000);
		$display("test reset values done");
		wr_reg(`BWM_A_START, 32'h0000_041a);
		wr_reg(`BWM_A_CTRL, 32'h0000_002c);
		bwm_trig_src_i.open_op(18'h0_0064, 18'h0_0000, 18'h0_0000);
		chk(alarm1, 1'b0);
		chk(ev_stamp, bwm_trig_src_i.t_last);
		wr_reg(`BWM_A_CTRL, 32'h0000_000d);
		repeat (3) @(posedge clk);
		chk(alarm1, 1'b1);
		rd_chk(`BWM_A_STAT, 32'h0000_0005);
		bwm_trig_src_i.open_op(18'h0_0000, 18'h0_0000, 18'h0_03e8);
		chk(alarm2, 1'b0);
		wr_reg(`BWM_A_CTRL, 32'h0000_000f);
		repeat (3) @(posedge clk);
		chk(alarm2, 1'b1);
		rd_chk(`BWM_A_STAT, 32'h0000_000e);
		$display("test alarm stages done");
		bwm_trig_src_i.open_op(18'h0_0000, 18'h0_07d0, 18'h0_0000);
		rd_chk(`BWM_A_LEFT0, 32'h0000_03b6);
		rd_chk(`BWM_A_LEFT0 + 8'h04, 32'h0000_0000);
		rd_chk(`BWM_A_LEFT0 + 8'h08, 32'h0000_0032);
		rd_chk(`BWM_A_OPS, 32'h0000_0003);
		rd_chk(`BWM_A_A1CNT, 32'h0000_0001);
		rd_chk(`BWM_A_A2CNT, 32'h0000_0001);
		chk(ev_n[0], 3);
		chk(ev_n[1] + ev_n[3], 2);
		$display("test deduction done");
		rd_chk(`BWM_A_LOG0 + 8'h08, 32'h0000_0000);
		rd_chk(`BWM_A_LOG0, bwm_trig_src_i.t_last[31:0]);
		rd_chk(`BWM_A_LOG0 + 8'h04, {16'h0000, bwm_trig_src_i.t_last[47:32]});
		rd_chk(`BWM_A_LOG0 + 8'h10, 32'h0000_5d8a);
		rd_chk(`BWM_A_LOG0 + 8'h28, 32'h0000_0000);
		rd_chk(`BWM_A_LOG0 + 8'h1c, 32'h0000_07d0);
		// one step back from the newest record is the alarm 2 ON record
		wr_reg(`BWM_A_LOGSEL, 32'h0000_0001);
		rd_chk(`BWM_A_LOG0 + 8'h08, 32'h0000_0003);
		rd_chk(`BWM_A_LOGCNT, 32'h0000_0005);
		$display("test log record done");
		chk(irq, 1'b0);
		wr_reg(`BWM_A_IRQMSK, 32'h0000_0001);
		@(posedge clk);
		chk(irq, 1'b1);
		wr_reg(`BWM_A_IRQST, 32'h0000_001f);
		@(posedge clk);
		chk(irq, 1'b0);
		$display("test interrupt done");
		// only ON events pass while the reload clears both alarms
		wr_reg(`BWM_A_CTRL, 32'h0000_0027);
		repeat (4) @(posedge clk);
		chk({alarm1, alarm2}, 2'b00);
		chk(ev_n[2] + ev_n[4], 0);
		// the OFF events are still raised, only their pulses are held back
		rd_chk(`BWM_A_IRQST, 32'h0000_0014);
		wr_reg(`BWM_A_CTRL, 32'h0000_0017);
		rd_chk(`BWM_A_OPS, 32'h0000_0000);
		rd_chk(`BWM_A_A1CNT, 32'h0000_0000);
		repeat (10) bwm_trig_src_i.open_op(18'h0_0000, 18'h0_0000, 18'h0_0000);
		rd_chk(`BWM_A_LOGCNT, 32'h0000_000c);
		rd_chk(`BWM_A_OPS, 32'h0000_000a);
		$display("test mode, clear and log roll done");
		tally_and_finish();
	end
endmodule
